// File: design/pdu_consts.vh
`ifndef PDU_CONSTS_VH
`define PDU_CONSTS_VH
// Channel count and selects
`define PDU_NCH 2
`define PDU_CHW 1
// Register index in bits [5:2], channel in bits [6]
`define PDU_IDX_HI 5
`define PDU_IDX_LO 2
`define PDU_CH_LO 6
`define PDU_REG_PTR 4'h0
`define PDU_REG_SEL 4'h1
`define PDU_REG_CNT 4'h2
`define PDU_REG_NPTR 4'h3
`define PDU_REG_NCNT 4'h4
`define PDU_REG_CMD 4'h5
`define PDU_REG_CFG 4'h6
`define PDU_REG_STATE 4'h7
`define PDU_REG_IEN 4'h8
`define PDU_REG_IDIS 4'h9
`define PDU_REG_IMSK 4'hA
`define PDU_REG_IFLG 4'hB
`define PDU_ADDR_W 12
// Command bits
`define PDU_CMD_GO 0
`define PDU_CMD_STOP 1
`define PDU_CMD_ERRCLR 8
// Config bits
`define PDU_CFG_SIZE_LO 0
`define PDU_CFG_SIZE_HI 1
`define PDU_CFG_EVENT_GATE_BIT 2
`define PDU_CFG_RING 3
// Item sizes
`define PDU_SZ_BYTE 2'h0
`define PDU_SZ_HALF 2'h1
`define PDU_SZ_WORD 2'h2
// Interrupt source bits
`define PDU_IRQ_RCZ 0
`define PDU_IRQ_TRC 1
`define PDU_IRQ_FAULT_FLAG 2
`define PDU_SEL_W 8
`endif

// File: design/pdu_peripheral_dma_unit.v
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "pdu_consts.vh"
module pdu_peripheral_dma_unit (
	input wire clk_sys,
	input wire srst,
	input wire [`PDU_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [`PDU_NCH-1:0] periph_req,
	output wire [`PDU_NCH-1:0] periph_ack,
	input wire [`PDU_NCH-1:0] periph_event,
	output wire [`PDU_NCH-1:0] event_overflow,
	output wire [`PDU_NCH-1:0] irq_line,
	output reg mem_req,
	output reg mem_write,
	output reg [31:0] mem_addr,
	output reg [1:0] mem_size,
	output reg [31:0] mem_wdata,
	input wire [31:0] mem_rdata,
	input wire mem_done,
	input wire mem_error,
	output reg per_req,
	output reg per_write,
	output reg [`PDU_SEL_W-1:0] per_id,
	output reg [31:0] per_wdata,
	input wire [31:0] per_rdata,
	input wire per_done
);
	localparam ST_IDLE = 2'h0;
	localparam ST_SRC = 2'h1;
	localparam ST_DST = 2'h2;

	reg [31:0] ptr_ff [0:`PDU_NCH-1];
	reg [15:0] cnt_ff [0:`PDU_NCH-1];
	reg [31:0] nptr_ff [0:`PDU_NCH-1];
	reg [15:0] ncnt_ff [0:`PDU_NCH-1];
	reg [`PDU_SEL_W-1:0] sel_ff [0:`PDU_NCH-1];
	reg [3:0] cfg_ff [0:`PDU_NCH-1];
	reg [`PDU_NCH-1:0] en_ff;
	reg [`PDU_NCH-1:0] err_ff;
	reg [`PDU_NCH-1:0] evt_ff;
	reg [`PDU_NCH-1:0] ovf_ff;
	reg [2:0] msk_ff [0:`PDU_NCH-1];
	reg [1:0] st_ff;
	reg [`PDU_CHW-1:0] cur_ff;
	reg [31:0] data_ff;
	reg [`PDU_NCH-1:0] ack_ff;

	wire [3:0] ridx = reg_addr[`PDU_IDX_HI:`PDU_IDX_LO];
	wire [`PDU_CHW-1:0] rch = reg_addr[`PDU_CH_LO+`PDU_CHW-1:`PDU_CH_LO];
	// Peripheral id MSB selects memory-to-peripheral direction
	wire cur_tx = sel_ff[cur_ff][`PDU_SEL_W-1];
	wire [1:0] cur_sz = cfg_ff[cur_ff][`PDU_CFG_SIZE_HI:`PDU_CFG_SIZE_LO];

	// Eligible channels and fixed priority pick
	reg [`PDU_NCH-1:0] elig;
	reg [`PDU_CHW-1:0] pick;
	reg pick_v;
	integer i;
	always @* begin
		elig = {`PDU_NCH{1'b0}};
		pick = {`PDU_CHW{1'b0}};
		pick_v = 1'b0;
		for (i = 0; i < `PDU_NCH; i = i + 1) begin
			// Counter nonzero required; a zero counter with reload reloads first
			elig[i] = en_ff[i] & ~err_ff[i] & periph_req[i] & (cnt_ff[i] != 16'h0000)
				& (~cfg_ff[i][`PDU_CFG_EVENT_GATE_BIT] | evt_ff[i]);
		end
		for (i = `PDU_NCH - 1; i >= 0; i = i - 1) begin
			if (elig[i]) begin
				pick = i[`PDU_CHW-1:0];
				pick_v = 1'b1;
			end
		end
	end

	assign periph_ack = ack_ff;
	assign event_overflow = ovf_ff;

	// Pointer step per width
	function [31:0] step;
		input [1:0] sz;
		begin
			case (sz)
				`PDU_SZ_BYTE: step = 32'h00000001;
				`PDU_SZ_HALF: step = 32'h00000002;
				default: step = 32'h00000004;
			endcase
		end
	endfunction

	function [31:0] trim;
		input [1:0] sz;
		input [31:0] d;
		begin
			case (sz)
				`PDU_SZ_BYTE: trim = {24'h000000, d[7:0]};
				`PDU_SZ_HALF: trim = {16'h0000, d[15:0]};
				default: trim = d;
			endcase
		end
	endfunction

	// Interrupt raw flags are levels derived from state, one flag block per channel
	wire [3*`PDU_NCH-1:0] raw_all;
	genvar g;
	generate
		for (g = 0; g < `PDU_NCH; g = g + 1) begin : gen_irq
			pdu_irq_flags #(
				.CW(16)
			) i_pdu_irq_flags (
				.cnt(cnt_ff[g]),
				.ncnt(ncnt_ff[g]),
				.err(err_ff[g]),
				.msk(msk_ff[g]),
				.raw(raw_all[3*g+2:3*g]),
				.irq(irq_line[g])
			);
		end
	endgenerate

	wire xfer_end = (st_ff == ST_DST) & (cur_tx ? per_done : mem_done);
	wire mem_fail = mem_error & ((st_ff == ST_SRC & cur_tx) | (st_ff == ST_DST & ~cur_tx));
	wire wr_cnt = reg_wr & (ridx == `PDU_REG_CNT);
	wire wr_ncnt = reg_wr & (ridx == `PDU_REG_NCNT);

	// All state sits in flops on one clock: a stopped clock freezes it in place
	integer c;
	always @(posedge clk_sys) begin
		if (srst) begin
			for (c = 0; c < `PDU_NCH; c = c + 1) begin
				ptr_ff[c] <= 32'h00000000;
				cnt_ff[c] <= 16'h0000;
				nptr_ff[c] <= 32'h00000000;
				ncnt_ff[c] <= 16'h0000;
				sel_ff[c] <= 8'h00;
				cfg_ff[c] <= 4'h0;
				msk_ff[c] <= 3'h0;
			end
			en_ff <= {`PDU_NCH{1'b0}};
			err_ff <= {`PDU_NCH{1'b0}};
			evt_ff <= {`PDU_NCH{1'b0}};
			ovf_ff <= {`PDU_NCH{1'b0}};
			ack_ff <= {`PDU_NCH{1'b0}};
			st_ff <= ST_IDLE;
			cur_ff <= {`PDU_CHW{1'b0}};
			data_ff <= 32'h00000000;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_size <= 2'h0;
			mem_wdata <= 32'h00000000;
			per_req <= 1'b0;
			per_write <= 1'b0;
			per_id <= 8'h00;
			per_wdata <= 32'h00000000;
		end else begin
			ack_ff <= {`PDU_NCH{1'b0}};
			ovf_ff <= {`PDU_NCH{1'b0}};
			for (c = 0; c < `PDU_NCH; c = c + 1) begin
				if (periph_event[c] & cfg_ff[c][`PDU_CFG_EVENT_GATE_BIT]) begin
					if (evt_ff[c] | (st_ff != ST_IDLE && cur_ff == c))
						ovf_ff[c] <= 1'b1;
					evt_ff[c] <= 1'b1;
				end
				// Reload when counter empties; also on reload write with counter zero
				if (cnt_ff[c] == 16'h0000 && ncnt_ff[c] != 16'h0000
					&& !(wr_ncnt && rch == c)) begin
					cnt_ff[c] <= ncnt_ff[c];
					ptr_ff[c] <= nptr_ff[c];
					if (!cfg_ff[c][`PDU_CFG_RING]) begin
						ncnt_ff[c] <= 16'h0000;
						nptr_ff[c] <= 32'h00000000;
					end
				end
			end
			case (st_ff)
				ST_IDLE: begin
					if (pick_v) begin
						cur_ff <= pick;
						ack_ff[pick] <= 1'b1;
						if (cfg_ff[pick][`PDU_CFG_EVENT_GATE_BIT])
							evt_ff[pick] <= periph_event[pick];
						st_ff <= ST_SRC;
						if (sel_ff[pick][`PDU_SEL_W-1]) begin
							mem_req <= 1'b1;
							mem_write <= 1'b0;
							mem_addr <= ptr_ff[pick];
							mem_size <= cfg_ff[pick][`PDU_CFG_SIZE_HI:`PDU_CFG_SIZE_LO];
						end else begin
							per_req <= 1'b1;
							per_write <= 1'b0;
							per_id <= sel_ff[pick];
						end
					end
				end
				ST_SRC: begin
					if (mem_fail) begin
						mem_req <= 1'b0;
						err_ff[cur_ff] <= 1'b1;
						st_ff <= ST_IDLE;
					end else if (cur_tx ? mem_done : per_done) begin
						mem_req <= 1'b0;
						per_req <= 1'b0;
						st_ff <= ST_DST;
						if (cur_tx) begin
							per_req <= 1'b1;
							per_write <= 1'b1;
							per_id <= sel_ff[cur_ff];
							per_wdata <= trim(cur_sz, mem_rdata);
						end else begin
							mem_req <= 1'b1;
							mem_write <= 1'b1;
							mem_addr <= ptr_ff[cur_ff];
							mem_size <= cur_sz;
							mem_wdata <= trim(cur_sz, per_rdata);
						end
					end
				end
				ST_DST: begin
					if (mem_fail) begin
						mem_req <= 1'b0;
						err_ff[cur_ff] <= 1'b1;
						st_ff <= ST_IDLE;
					end else if (xfer_end) begin
						mem_req <= 1'b0;
						per_req <= 1'b0;
						st_ff <= ST_IDLE;
						cnt_ff[cur_ff] <= cnt_ff[cur_ff] - 16'h0001;
						ptr_ff[cur_ff] <= ptr_ff[cur_ff] + step(cur_sz);
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
			// Software writes last so they take effect over engine updates
			if (reg_wr) begin
				case (ridx)
					`PDU_REG_PTR: ptr_ff[rch] <= reg_wdata;
					`PDU_REG_SEL: sel_ff[rch] <= reg_wdata[`PDU_SEL_W-1:0];
					`PDU_REG_CNT: cnt_ff[rch] <= reg_wdata[15:0];
					`PDU_REG_NPTR: nptr_ff[rch] <= reg_wdata;
					`PDU_REG_NCNT: begin
						if (cnt_ff[rch] == 16'h0000) begin
							cnt_ff[rch] <= reg_wdata[15:0];
							ptr_ff[rch] <= nptr_ff[rch];
						end else
							ncnt_ff[rch] <= reg_wdata[15:0];
					end
					`PDU_REG_CMD: begin
						if (reg_wdata[`PDU_CMD_GO])
							en_ff[rch] <= 1'b1;
						if (reg_wdata[`PDU_CMD_STOP])
							en_ff[rch] <= 1'b0;
						// A fault raised in the same cycle wins over the clear
						if (reg_wdata[`PDU_CMD_ERRCLR] && !(mem_fail && cur_ff == rch))
							err_ff[rch] <= 1'b0;
					end
					`PDU_REG_CFG: cfg_ff[rch] <= reg_wdata[3:0];
					`PDU_REG_IEN: msk_ff[rch] <= msk_ff[rch] | reg_wdata[2:0];
					`PDU_REG_IDIS: msk_ff[rch] <= msk_ff[rch] & ~reg_wdata[2:0];
					default: ;
				endcase
			end
		end
	end

	// Read mux, data valid one cycle after strobe
	always @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (ridx)
				`PDU_REG_PTR: reg_rdata <= ptr_ff[rch];
				`PDU_REG_SEL: reg_rdata <= {24'h000000, sel_ff[rch]};
				`PDU_REG_CNT: reg_rdata <= {16'h0000, cnt_ff[rch]};
				`PDU_REG_NPTR: reg_rdata <= nptr_ff[rch];
				`PDU_REG_NCNT: reg_rdata <= {16'h0000, ncnt_ff[rch]};
				`PDU_REG_CFG: reg_rdata <= {28'h0000000, cfg_ff[rch]};
				`PDU_REG_STATE: reg_rdata <= {31'h00000000, en_ff[rch]};
				`PDU_REG_IMSK: reg_rdata <= {29'h00000000, msk_ff[rch]};
				`PDU_REG_IFLG: reg_rdata <= {29'h00000000, raw_all[3*rch+:3]};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule

// Raw interrupt flags and masked request of one channel
module pdu_irq_flags #(
	parameter CW = 16
) (
	input wire [CW-1:0] cnt,
	input wire [CW-1:0] ncnt,
	input wire err,
	input wire [2:0] msk,
	output wire [2:0] raw,
	output wire irq
);
	assign raw[`PDU_IRQ_RCZ] = ncnt == {CW{1'b0}};
	assign raw[`PDU_IRQ_TRC] = (cnt == {CW{1'b0}}) & (ncnt == {CW{1'b0}});
	assign raw[`PDU_IRQ_FAULT_FLAG] = err;
	assign irq = |(raw & msk);
endmodule

// File: testbench/pdu_properties.sv
`timescale 1ns/100ps
`include "pdu_consts.vh"
module pdu_properties (
	input wire clk_sys,
	input wire srst,
	input wire [`PDU_NCH-1:0] periph_req,
	input wire [`PDU_NCH-1:0] periph_ack,
	input wire [`PDU_NCH-1:0] periph_event,
	input wire [`PDU_NCH-1:0] event_overflow,
	input wire mem_req,
	input wire mem_done,
	input wire mem_error,
	input wire [31:0] mem_addr,
	input wire per_req,
	input wire per_write,
	input wire [`PDU_SEL_W-1:0] per_id,
	input wire per_done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	ack_cause_a: assert property (periph_ack[0] |-> $past(periph_req[0])) else $error("bad ack");
	ack_start_a: assert property (|periph_ack |-> mem_req || per_req) else $error("idle ack");
	one_ack_a: assert property ($onehot0(periph_ack)) else $error("two acks");
	one_phase_a: assert property (!(mem_req && per_req)) else $error("two phases");
	mem_hold_a: assert property (mem_req && !mem_done && !mem_error |=>
		mem_req && $stable(mem_addr)) else $error("mem request moved");
	per_hold_a: assert property (per_req && !per_done |=>
		per_req && $stable(per_id)) else $error("peripheral request moved");
	read_first_a: assert property (mem_done && per_id[7] |=>
		per_req && per_write) else $error("no peripheral write");
	err_halt_a: assert property (mem_error |=> !mem_req && !per_req) else $error("no halt");
	ovf_cause_a: assert property (event_overflow[1] |-> $past(periph_event[1])) else $error("ovf");
	cover property (mem_error);
	cover property (per_req && per_write);
	cover property (|event_overflow);
endmodule

// File: testbench/pdu_far_model.sv
`timescale 1ns/100ps
module pdu_far_model (
	input wire clk_sys,
	input wire [3:0] dly,
	input wire mem_req,
	input wire [31:0] mem_addr,
	output wire [31:0] mem_rdata,
	output wire mem_done,
	output wire mem_error,
	input wire per_req,
	output wire [31:0] per_rdata,
	output wire per_done
);
	reg [3:0] mc = 4'h0;
	reg [3:0] pc = 4'h0;
	reg mb = 1'b0;
	reg pb = 1'b0;
	// Top page is unmapped memory
	wire bad = mem_addr[31:28] == 4'hF;
	wire [31:0] md = {mem_addr[15:0], 16'hC3A5};
	always @(posedge clk_sys) begin
		mb <= mem_req && !mb && mc == dly;
		mc <= (mem_req && !mb) ? mc + 4'h1 : 4'h0;
		pb <= per_req && !pb && pc == dly;
		pc <= (per_req && !pb) ? pc + 4'h1 : 4'h0;
	end
	// Inverted when not answering, so stale data never passes
	assign mem_rdata = mb ? md : ~md;
	assign mem_done = mb && !bad;
	assign mem_error = mb && bad;
	assign per_rdata = pb ? 32'hA5C3_96E1 : 32'h5A3C_691E;
	assign per_done = pb;
endmodule

// File: testbench/pdu_peripheral_dma_unit_tb.sv
`timescale 1ns/100ps
`include "pdu_consts.vh"
module pdu_peripheral_dma_unit_tb;
	reg clk_sys = 1'b0;
	reg srst = 1'b1;
	reg [11:0] reg_addr = 12'h000;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [1:0] periph_req = 2'h0;
	reg [1:0] periph_event = 2'h0;
	reg [3:0] dly = 4'h0;
	reg ovf_seen = 1'b0;
	int acks1 = 0;
	int n_fail = 0;
	int tests_run = 0;
	wire [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, per_wdata, per_rdata;
	wire [1:0] periph_ack, event_overflow, irq_line, mem_size;
	wire [7:0] per_id;
	wire mem_req, mem_write, mem_done, mem_error, per_req, per_write, per_done;
	always #5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		acks1 = acks1 + (periph_ack[1] === 1'b1);
		ovf_seen = ovf_seen | (event_overflow[1] === 1'b1);
	end
	pdu_peripheral_dma_unit i_pdu_peripheral_dma_unit (.clk_sys(clk_sys), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .periph_req(periph_req), .periph_ack(periph_ack),
		.periph_event(periph_event), .event_overflow(event_overflow), .irq_line(irq_line),
		.mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done),
		.mem_error(mem_error), .per_req(per_req), .per_write(per_write), .per_id(per_id),
		.per_wdata(per_wdata), .per_rdata(per_rdata), .per_done(per_done));
	pdu_far_model i_pdu_far_model (.clk_sys(clk_sys), .dly(dly), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_done(mem_done),
		.mem_error(mem_error), .per_req(per_req), .per_rdata(per_rdata), .per_done(per_done));
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input int c, input [3:0] i, input [31:0] d);
		@(posedge clk_sys);
		reg_addr <= {5'h0, c[0], i, 2'h0};
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rdc(input int c, input [3:0] i, input [31:0] e);
		@(posedge clk_sys);
		reg_addr <= {5'h0, c[0], i, 2'h0};
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk($sformatf("reg %0d.%0d", c, i), reg_rdata, e);
	endtask
	task setup(input int c, input [31:0] cfg, input [31:0] p, input [31:0] n);
		wr(c, `PDU_REG_SEL, 8'h85);
		wr(c, `PDU_REG_CFG, cfg);
		wr(c, `PDU_REG_PTR, p);
		wr(c, `PDU_REG_CNT, n);
		wr(c, `PDU_REG_CMD, 32'h1);
	endtask
	// One item on channel c, memory phase must sit at address a
	task xfer(input int c, input [31:0] a, input [1:0] s, input bit d);
		int i;
		reg [31:0] m;
		m = s == `PDU_SZ_BYTE ? 32'hFF : s == `PDU_SZ_HALF ? 32'hFFFF : 32'hFFFF_FFFF;
		@(posedge clk_sys);
		periph_req[c] <= 1'b1;
		for (i = 0; i < 20 && periph_ack[c] !== 1'b1; i++)
			@(negedge clk_sys);
		chk("ack", periph_ack[c], 1'b1);
		if (i == 20)
			results();
		for (i = 0; i < 60 && (mem_req || per_req); i++) begin
			if (mem_req)
				chk("addr", mem_addr, a);
			if (mem_req)
				chk("size dir", {mem_size, mem_write}, {s, !d});
			if (per_req && per_write)
				chk("upper", per_wdata & ~m, 32'h0);
			if (per_req && per_write)
				chk("per data", per_wdata, {a[15:0], 16'hC3A5} & m);
			if (mem_req && mem_write)
				chk("mem data", mem_wdata, 32'hA5C3_96E1 & m);
			@(posedge clk_sys);
			periph_req <= 2'h0;
			@(negedge clk_sys);
		end
		if (i == 60)
			results();
	endtask
	task t_regs;
		rdc(0, `PDU_REG_PTR, 0);
		rdc(0, 4'hC, 0);
		wr(1, `PDU_REG_CNT, 32'h1234_5678);
		rdc(1, `PDU_REG_CNT, 32'h5678);
		wr(1, `PDU_REG_CMD, 32'h1);
		rdc(1, `PDU_REG_STATE, 1);
		wr(1, `PDU_REG_CMD, 32'h2);
		rdc(1, `PDU_REG_STATE, 0);
		wr(1, `PDU_REG_CNT, 0);
	endtask
	task t_move;
		for (int d = 0; d < 2; d++)
			for (int s = 0; s < 3; s++) begin
				@(posedge clk_sys);
				dly <= 4'(s * 3);
				wr(0, `PDU_REG_SEL, {d[0], 7'h05});
				wr(0, `PDU_REG_CFG, s);
				wr(0, `PDU_REG_PTR, 32'h1000);
				wr(0, `PDU_REG_CNT, 2);
				wr(0, `PDU_REG_CMD, 32'h1);
				xfer(0, 32'h1000, s[1:0], d[0]);
				rdc(0, `PDU_REG_CNT, 1);
				xfer(0, 32'h1000 + (1 << s), s[1:0], d[0]);
				rdc(0, `PDU_REG_PTR, 32'h1000 + (2 << s));
				rdc(0, `PDU_REG_IFLG, 3);
			end
	endtask
	task t_reload;
		wr(0, `PDU_REG_NPTR, 32'h3000);
		setup(0, `PDU_SZ_WORD, 32'h2000, 1);
		wr(0, `PDU_REG_NCNT, 2);
		xfer(0, 32'h2000, `PDU_SZ_WORD, 1);
		rdc(0, `PDU_REG_PTR, 32'h3000);
		rdc(0, `PDU_REG_CNT, 2);
		rdc(0, `PDU_REG_NPTR, 0);
		rdc(0, `PDU_REG_NCNT, 0);
		wr(1, `PDU_REG_NPTR, 32'h4000);
		wr(1, `PDU_REG_NCNT, 5);
		rdc(1, `PDU_REG_CNT, 5);
		rdc(1, `PDU_REG_PTR, 32'h4000);
		setup(1, 32'hA, 32'h5000, 1);
		wr(1, `PDU_REG_NPTR, 32'h6000);
		wr(1, `PDU_REG_NCNT, 1);
		xfer(1, 32'h5000, `PDU_SZ_WORD, 1);
		xfer(1, 32'h6000, `PDU_SZ_WORD, 1);
		rdc(1, `PDU_REG_NCNT, 1);
		// Software stops channel 1, whose ring reload keeps it armed
		wr(1, `PDU_REG_CMD, 32'h2);
	endtask
	task t_prio;
		int i;
		setup(0, `PDU_SZ_WORD, 32'h7000, 1);
		setup(1, `PDU_SZ_WORD, 32'h8000, 1);
		@(posedge clk_sys);
		periph_req <= 2'h3;
		for (i = 0; i < 20 && periph_ack === 2'h0; i++)
			@(negedge clk_sys);
		chk("first ack", periph_ack, 2'h1);
		@(posedge clk_sys);
		periph_req <= 2'h0;
		for (i = 0; i < 60 && (mem_req || per_req); i++)
			@(negedge clk_sys);
		xfer(1, 32'h8000, `PDU_SZ_WORD, 1);
	endtask
	task t_error;
		reg seen;
		wr(0, `PDU_REG_IEN, 32'h4);
		setup(0, `PDU_SZ_WORD, 32'hF000_0000, 2);
		xfer(0, 32'hF000_0000, `PDU_SZ_WORD, 1);
		rdc(0, `PDU_REG_IFLG, 5);
		rdc(0, `PDU_REG_IMSK, 4);
		chk("irq", irq_line, 2'h1);
		@(posedge clk_sys);
		periph_req[0] <= 1'b1;
		seen = 1'b0;
		repeat (10) @(negedge clk_sys) seen = seen | periph_ack[0];
		chk("halted", seen, 0);
		wr(0, `PDU_REG_IDIS, 32'h4);
		@(negedge clk_sys);
		chk("irq off", irq_line, 0);
		wr(0, `PDU_REG_PTR, 32'h9000);
		wr(0, `PDU_REG_CMD, 32'h101);
		xfer(0, 32'h9000, `PDU_SZ_WORD, 1);
	endtask
	task t_event;
		setup(1, 32'h6, 32'hA000, 3);
		@(posedge clk_sys);
		periph_req[1] <= 1'b1;
		acks1 = 0;
		repeat (8) @(posedge clk_sys);
		chk("held", acks1, 0);
		periph_event[1] <= 1'b1;
		@(posedge clk_sys);
		periph_event[1] <= 1'b0;
		repeat (30) @(posedge clk_sys);
		chk("one item", acks1, 1);
		dly <= 4'h8;
		periph_event[1] <= 1'b1;
		repeat (4) @(posedge clk_sys);
		periph_event[1] <= 1'b0;
		repeat (40) @(posedge clk_sys);
		chk("overflow", ovf_seen, 1);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		t_regs();
		t_move();
		t_reload();
		t_prio();
		t_error();
		t_event();
		results();
	end
endmodule
bind pdu_peripheral_dma_unit pdu_properties i_pdu_properties (.clk_sys(clk_sys), .srst(srst),
	.periph_req(periph_req), .periph_ack(periph_ack), .periph_event(periph_event),
	.event_overflow(event_overflow), .mem_req(mem_req), .mem_done(mem_done),
	.mem_error(mem_error), .mem_addr(mem_addr), .per_req(per_req), .per_write(per_write),
	.per_id(per_id), .per_done(per_done));
